// *** src/qhb_regs.svh ***
// constants of the quad half-bridge control block
// assumes a 20 MHz pclk; included by both ends
`ifndef QHB_REGS_SVH
`define QHB_REGS_SVH
// Behaviour
// - enable low puts output high impedance
// - enable high drives output to level
// - fast decay PWM on enable, slow on level
// - slow decay: enables high, PWM one level
// - fast decay: fixed levels, PWM both enables
// - sleep low stops the charge pump
// - persistent limit disables channel, raises fault
// - overcurrent latch clears only by reset/power
// - either FET side limit trips overcurrent
// - thermal disables all, auto resumes
// - low supply disables all, resets logic
// - reset low clears logic, disables drivers
// - sleep disables bridges, clocks, ignores inputs
// - host waits 1 ms after wake
// - host drives reset and sleep high
// - overcurrent deglitch is 5 us
// ----------------------------------------
// timing
// ----------------------------------------
`define QHB_CLK_HZ        20000000
`define QHB_OCP_DEGLITCH_NS 5000
`define QHB_OCP_CYCLES    ((`QHB_OCP_DEGLITCH_NS * (`QHB_CLK_HZ / 1000000) + 999) / 1000)
`define QHB_WAKE_US       1000
`define QHB_WAKE_CYCLES   (`QHB_WAKE_US * (`QHB_CLK_HZ / 1000000))
// ----------------------------------------
// host register map (apb)
// ----------------------------------------
`define QHB_REG_CTRL      12'h000
`define QHB_REG_STAT      12'h004
`define QHB_CTRL_RESET    32'h0000_0000
// ctrl fields
`define QHB_CTRL_MODE_LSB 0
`define QHB_CTRL_DIR_BIT  2
`define QHB_CTRL_CLR_BIT  4
`define QHB_CTRL_SLP_BIT  5
`define QHB_CTRL_DUTY_LSB 8
`define QHB_CTRL_PER_LSB  16
`endif

// *** src/qhb_pkg.sv ***
// types of the quad half-bridge control block
// assumes qhb_regs.svh for the numbers
package qhb_pkg;
    typedef enum logic [3:0] {
        QHB_COAST = 4'h1,
        QHB_SLOW  = 4'h2,
        QHB_FAST  = 4'h4,
        QHB_BRAKE = 4'h8
    } qhb_mode_t;
endpackage

// *** src/qhb_if.sv ***
// link between host controller and driver logic
// assumes the bench resolves fault_flag_low from its enable
`timescale 1ns/10ps
interface qhb_if #(parameter int CH = 4);
    logic [CH-1:0] level_cmd;
    logic [CH-1:0] drive_allow;
    logic          logic_clear_low;
    logic          low_power_req_low;
    logic          fault_flag_low_oe;
    logic          fault_flag_low_in;
    modport host (
        output level_cmd, drive_allow, logic_clear_low, low_power_req_low,
        input  fault_flag_low_in
    );
    modport dev (
        input  level_cmd, drive_allow, logic_clear_low, low_power_req_low,
        output fault_flag_low_oe
    );
endinterface

// *** src/qhb_ocp_filt.sv ***
// overcurrent deglitch and latch of one channel
// assumes limit flags synchronous to pclk
`timescale 1ns/10ps
module qhb_ocp_filt #(
    parameter int CYCLES = 100
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic clear,
    input  wire logic hs_limit,
    input  wire logic ls_limit,
    // status
    output logic      tripped
);
    logic [$clog2(CYCLES+1)-1:0] cnt_q;
    logic                        trip_q;
    wire limit = hs_limit | ls_limit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clear || !limit || trip_q) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // latch stays until clear; no automatic recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_q <= 1'b0;
        end else if (clear) begin
            trip_q <= 1'b0;
        end else if (limit && cnt_q >= ($clog2(CYCLES+1))'(CYCLES - 1)) begin
            trip_q <= 1'b1;
        end
    end

    assign tripped = trip_q;
endmodule

// *** src/qhb_dev.sv ***
// device end: bridge decode and protection of four half-bridges
// assumes analog flags synchronous to pclk; presetn models supply power
`timescale 1ns/10ps
`include "qhb_regs.svh"
module qhb_dev #(
    parameter int CH         = 4,
    parameter int OCP_CYCLES = `QHB_OCP_CYCLES
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // link
    qhb_if.dev                 lnk,
    // analog monitors
    input  wire logic [CH-1:0] hs_limit,
    input  wire logic [CH-1:0] ls_limit,
    input  wire logic          thermal_trip,
    input  wire logic          supply_low_lockout,
    // power stage
    output logic      [CH-1:0] hb_drive_en,
    output logic      [CH-1:0] hb_level,
    output logic               charge_pump_en,
    output logic               int_clk_en,
    output logic      [CH-1:0] ocp_status
);
    // ----------------------------------------
    // logic reset and sleep
    // ----------------------------------------
    logic          clr_logic;
    logic [CH-1:0] trip;
    // supply loss resets logic as reset does
    assign clr_logic = !lnk.logic_clear_low || supply_low_lockout;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            qhb_ocp_filt #(.CYCLES(OCP_CYCLES)) u_ocp (
                .pclk     (pclk),
                .presetn  (presetn),
                .clear    (clr_logic),
                .hs_limit (hs_limit[g] & hb_drive_en[g]),
                .ls_limit (ls_limit[g] & hb_drive_en[g]),
                .tripped  (trip[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // output decode
    // ----------------------------------------
    logic all_off;
    assign all_off = clr_logic || !lnk.low_power_req_low || thermal_trip;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_drive_en <= '0;
            hb_level    <= '0;
        end else if (all_off) begin
            hb_drive_en <= '0;
            hb_level    <= '0;
        end else begin
            hb_drive_en <= lnk.drive_allow & ~trip;
            hb_level    <= lnk.level_cmd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_pump_en <= 1'b0;
            int_clk_en     <= 1'b0;
        end else begin
            charge_pump_en <= lnk.low_power_req_low;
            int_clk_en     <= lnk.low_power_req_low;
        end
    end

    // ----------------------------------------
    // fault flag, open drain
    // ----------------------------------------
    logic fault_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= (|trip) || thermal_trip || supply_low_lockout;
        end
    end
    assign lnk.fault_flag_low_oe = fault_q;
    assign ocp_status = trip;
endmodule

// *** src/qhb_host.sv ***
// host end: apb registers steering pwm on one channel pair
// assumes fault_flag_low_in resolved with pull-up by the bench
`timescale 1ns/10ps
`include "qhb_regs.svh"
module qhb_host #(
    parameter int CH           = 4,
    parameter int WAKE_CYCLES  = `QHB_WAKE_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // link
    qhb_if.host              lnk
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] prdata_q;
    logic [15:0] wake_q;
    logic [7:0]  pcnt_q;
    logic        pwm;
    logic        acc;
    qhb_pkg::qhb_mode_t mode;

    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && paddr != `QHB_REG_CTRL && paddr != `QHB_REG_STAT;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `QHB_CTRL_RESET;
        end else if (acc && pwrite && paddr == `QHB_REG_CTRL) begin
            ctrl_q <= pwdata;
        end
    end

    // read data registered in setup so it is valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `QHB_REG_CTRL: prdata_q <= ctrl_q;
                `QHB_REG_STAT: prdata_q <= {30'h0, wake_q == 16'h0000, !lnk.fault_flag_low_in};
                default:       prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // pwm and wake timer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_q <= 8'h00;
        end else if (pcnt_q >= ctrl_q[`QHB_CTRL_PER_LSB +: 8]) begin
            pcnt_q <= 8'h00;
        end else begin
            pcnt_q <= pcnt_q + 8'h01;
        end
    end
    assign pwm = pcnt_q < ctrl_q[`QHB_CTRL_DUTY_LSB +: 8];

    // long wake counts slow simulations down; width covers 20000
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 16'h0000;
        end else if (ctrl_q[`QHB_CTRL_SLP_BIT]) begin
            wake_q <= 16'(WAKE_CYCLES);
        end else if (wake_q != 16'h0000) begin
            wake_q <= wake_q - 16'h0001;
        end
    end

    always_comb begin
        case (ctrl_q[`QHB_CTRL_MODE_LSB +: 2])
            2'h1:    mode = qhb_pkg::QHB_SLOW;
            2'h2:    mode = qhb_pkg::QHB_FAST;
            2'h3:    mode = qhb_pkg::QHB_BRAKE;
            default: mode = qhb_pkg::QHB_COAST;
        endcase
    end

    // ----------------------------------------
    // link drive, channels 0 and 1 form the pair
    // ----------------------------------------
    logic dir;
    logic busy;
    assign dir  = ctrl_q[`QHB_CTRL_DIR_BIT];
    assign busy = wake_q != 16'h0000;
    assign lnk.logic_clear_low   = !ctrl_q[`QHB_CTRL_CLR_BIT];
    assign lnk.low_power_req_low = !ctrl_q[`QHB_CTRL_SLP_BIT];

    always_comb begin
        lnk.level_cmd   = '0;
        lnk.drive_allow = '0;
        if (!busy) begin
            case (mode)
                qhb_pkg::QHB_SLOW: begin
                    lnk.drive_allow[1:0] = 2'h3;
                    lnk.level_cmd[1:0]   = dir ? {pwm, 1'b0} : {1'b0, pwm};
                end
                qhb_pkg::QHB_FAST: begin
                    lnk.drive_allow[1:0] = {pwm, pwm};
                    lnk.level_cmd[1:0]   = dir ? 2'h2 : 2'h1;
                end
                qhb_pkg::QHB_BRAKE: begin
                    lnk.drive_allow[1:0] = 2'h3;
                end
                qhb_pkg::QHB_COAST: begin
                    lnk.drive_allow = '0;
                end
                default: begin
                    lnk.drive_allow = '0;
                end
            endcase
        end
    end
endmodule

// *** tb/qhb_props.sv ***
// assertions on the link between the host end and the device end
// assumes instantiation beside qhb_if in the testbench
`timescale 1ns/10ps
module qhb_props #(
    parameter int CH  = 4,
    parameter int OCP = 4
) (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // link
    input wire logic [CH-1:0] level_cmd,
    input wire logic [CH-1:0] drive_allow,
    input wire logic          logic_clear_low,
    input wire logic          low_power_req_low,
    input wire logic          fault_flag_low_oe,
    // device pins
    input wire logic [CH-1:0] hs_limit,
    input wire logic [CH-1:0] ls_limit,
    input wire logic          thermal_trip,
    input wire logic          supply_low_lockout,
    input wire logic [CH-1:0] hb_drive_en,
    input wire logic [CH-1:0] hb_level,
    input wire logic          charge_pump_en,
    input wire logic [CH-1:0] ocp_status
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire          run = logic_clear_low && low_power_req_low && !thermal_trip
                        && !supply_low_lockout;
    wire [CH-1:0] lim = hs_limit | ls_limit;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_bridge_enable: assert property (
        run |=> hb_drive_en == $past(drive_allow & ~ocp_status))
        else $error("bridge enable wrong");
    a_bridge_level: assert property (
        run |=> ((hb_level ^ $past(level_cmd)) & hb_drive_en) == '0)
        else $error("bridge level wrong");
    a_sleep_pump: assert property (
        !low_power_req_low |=> !charge_pump_en)
        else $error("charge pump runs in sleep");
    a_all_off: assert property (
        !run |=> hb_drive_en == '0)
        else $error("bridge driven while shut down");
    a_trip_clear: assert property (
        !logic_clear_low || supply_low_lockout |=> ocp_status == '0)
        else $error("trip survives clear");
    a_fault_flag: assert property (
        1'b1 |=> fault_flag_low_oe == $past(thermal_trip || supply_low_lockout || |ocp_status))
        else $error("fault line wrong");
    a_trip_hold: assert property (
        logic_clear_low && !supply_low_lockout |=> (ocp_status & $past(ocp_status)) == $past(ocp_status))
        else $error("trip lost");
    // a trip needs the limit at both ends of the deglitch window
    a_trip_glitch: assert property (
        (ocp_status & ~$past(ocp_status) & ~($past(lim, OCP) & $past(lim))) == '0)
        else $error("trip too early");
endmodule

// *** tb/testbench.sv ***
// bench: apb drives the host end, the device end follows on the link
// assumes src/ compiled first and a 20 MHz pclk
`timescale 1ns/10ps
`include "qhb_regs.svh"
module testbench;
    localparam int OCP = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  hs, ls, en, lvl, ocp, da, lc;
    logic        thermal_trip, supply_low_lockout, cp_en, clk_en;
    int          err_total, checks, n, hi;
    qhb_if #(.CH(4)) lnk ();
    assign lnk.fault_flag_low_in = !lnk.fault_flag_low_oe; // pull-up on the line
    wire         flt = lnk.fault_flag_low_in;
    qhb_host #(.WAKE_CYCLES(20)) u_qhb_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
    qhb_dev #(.OCP_CYCLES(OCP)) u_qhb_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev),
        .hs_limit(hs), .ls_limit(ls), .thermal_trip(thermal_trip),
        .supply_low_lockout(supply_low_lockout), .hb_drive_en(en), .hb_level(lvl),
        .charge_pump_en(cp_en), .int_clk_en(clk_en), .ocp_status(ocp));
    qhb_props #(.OCP(OCP)) u_qhb_props (.pclk(pclk), .presetn(presetn),
        .level_cmd(lnk.level_cmd), .drive_allow(lnk.drive_allow),
        .logic_clear_low(lnk.logic_clear_low), .low_power_req_low(lnk.low_power_req_low),
        .fault_flag_low_oe(lnk.fault_flag_low_oe), .hs_limit(hs), .ls_limit(ls),
        .thermal_trip(thermal_trip), .supply_low_lockout(supply_low_lockout),
        .hb_drive_en(en), .hb_level(lvl), .charge_pump_en(cp_en), .ocp_status(ocp));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            results();
        end
    endtask
    // duty 2 of a period of 4, so pwm toggles
    task automatic ctrl(input logic [1:0] m, input logic d, c, s);
        apb(1'b1, `QHB_REG_CTRL, {16'h0003, 8'h02, 2'b00, s, c, 1'b0, d, m});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            apb(1'b0, `QHB_REG_STAT, 32'h0);
            k++;
        end while (rd[1] !== 1'b1 && k < 100);
        chk(rd[1], 1'b1);
        if (k >= 100) results();
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {hs, ls, thermal_trip, supply_low_lockout, err_total, checks} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        chk({flt, cp_en}, 2'b11);
        apb(1'b0, `QHB_REG_CTRL, 32'h0);
        chk(rd, `QHB_CTRL_RESET);
        apb(1'b1, 12'h0F0, 32'h1);
        chk(se, 1'b1);
        wait_ready;
        $display("reset test done");
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                ctrl(m[1:0], d[0], 1'b0, 1'b0);
                tick(3);
                hi = 0;
                repeat (16) begin
                    da = lnk.drive_allow;
                    lc = lnk.level_cmd;
                    tick(1);
                    chk(en, da);
                    chk(lvl & da, lc & da);
                    if (m == 0) chk(da, 4'h0);
                    if (m == 1) chk({da[1:0], lc[!d]}, 3'b110);
                    if (m == 2) chk({lc[1:0], da[0]}, {d ? 2'b10 : 2'b01, da[1]});
                    if (m == 3) chk({da[1:0], lc[1:0]}, 4'hC);
                    hi += (m == 1) ? lc[d] : da[0];
                end
                if (m == 1 || m == 2) chk(hi > 0 && hi < 16, 1'b1);
            end
        end
        $display("bridge test done");
        ctrl(2'd1, 1'b0, 1'b0, 1'b0);
        @(posedge pclk);
        ls <= 4'h1;
        repeat (OCP - 1) @(posedge pclk);
        ls <= 4'h0;
        hs <= 4'h2;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (ocp[1] !== 1'b1 && n < 20);
        chk(n, OCP);
        chk(ocp, 4'h2);
        tick(2);
        chk({en[1:0], flt}, 3'b010);
        @(posedge pclk);
        hs <= 4'h0;
        tick(10);
        chk({ocp, flt}, 5'h04);
        ctrl(2'd1, 1'b0, 1'b1, 1'b0);
        tick(2);
        chk({en, ocp}, 8'h00);
        ctrl(2'd1, 1'b0, 1'b0, 1'b0);
        tick(2);
        chk({en[1:0], flt}, 3'b111);
        $display("overcurrent test done");
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            hs <= 4'h1;
            repeat (OCP + 1) @(posedge pclk);
            hs <= 4'h0;
            thermal_trip <= (i == 0);
            supply_low_lockout <= (i == 1);
            tick(2);
            chk({en, flt}, 5'h00);
            @(posedge pclk);
            thermal_trip <= 1'b0;
            supply_low_lockout <= 1'b0;
            tick(2);
            chk({en[1], ocp[0], flt}, {1'b1, i == 0, i == 1});
            ctrl(2'd1, 1'b0, 1'b1, 1'b0);
            ctrl(2'd1, 1'b0, 1'b0, 1'b0);
        end
        $display("shutdown test done");
        ctrl(2'd1, 1'b0, 1'b0, 1'b1);
        @(posedge pclk);
        hs <= 4'hF;
        tick(OCP + 2);
        chk({cp_en, clk_en, en, ocp}, 10'h000);
        @(posedge pclk);
        hs <= 4'h0;
        ctrl(2'd1, 1'b0, 1'b0, 1'b0);
        tick(2);
        chk({cp_en, clk_en}, 2'b11);
        chk(lnk.drive_allow, 4'h0);
        wait_ready;
        tick(2);
        chk(en[1:0], 2'b11);
        $display("sleep test done");
        // supply power cycle is another way out of a trip, besides clear and supply lockout
        @(posedge pclk);
        ls <= 4'h1;
        repeat (OCP + 1) @(posedge pclk);
        ls <= 4'h0;
        tick(1);
        chk(ocp, 4'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        chk({ocp, flt}, 5'h01);
        $display("power cycle test done");
        results();
    end
endmodule
